// >>> src/hrs_return_stack.sv
// Return address stack with Wishbone register access
`timescale 1ns/100ps
`include "hrs_params.svh"
module hrs_return_stack (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire hrs_pkg::hrs_core_s CORE_IN,
    input wire logic STACK_ERROR_RESET_ENABLE,
    input wire hrs_pkg::hrs_wb_req_s WB_REQ,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [20:0] TOP_STACK_ENTRY,
    output logic STACK_RESET_REQ,
    output logic IRQ
);
    import hrs_pkg::*;

    logic [`HRS_PC_W-1:0] mem_q [1:`HRS_DEPTH];
    logic [`HRS_PTR_W-1:0] ptr_q;
    logic full_q;
    logic unf_q;
    logic [1:0] ist_q;
    logic [1:0] imask_q;
    logic ack_q;
    logic [31:0] rdat_q;
    logic rst_req_q;
    logic irq_q;
    logic [`HRS_PC_W-1:0] top_q;

    logic acc;
    logic wr;
    logic at_max;
    logic at_zero;
    logic do_push;
    logic do_pop;
    logic ev_full;
    logic ev_unf;
    logic [`HRS_PC_W-1:0] top_rd;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        hit = (a == r);
    endfunction

    assign acc = WB_REQ.cyc && WB_REQ.stb && !ack_q;
    assign wr = acc && WB_REQ.we && WB_REQ.sel[0];
    assign at_max = (ptr_q == `HRS_PTR_MAX);
    assign at_zero = (ptr_q == `HRS_PTR_ZERO);
    assign do_push = CORE_IN.push;
    assign do_pop = CORE_IN.pop && !CORE_IN.push;
    // Full when the push lands in the last slot, or beyond it
    assign ev_full = do_push &&
        (at_max || ptr_q == `HRS_PTR_MAX - `HRS_PTR_ONE);
    assign ev_unf = do_pop && at_zero;
    assign top_rd = at_zero ? '0 : mem_q[ptr_q];

    // Pointer
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ptr_q <= `HRS_PTR_ZERO;
        end else if (do_push && !at_max) begin
            ptr_q <= ptr_q + `HRS_PTR_ONE;
        end else if (do_pop && !at_zero) begin
            ptr_q <= ptr_q - `HRS_PTR_ONE;
        end else if (wr && hit(WB_REQ.adr, `HRS_ADR_PTR) &&
                !CORE_IN.push && !CORE_IN.pop) begin
            // Core operation at a limit outranks a software move
            ptr_q <= WB_REQ.dat[`HRS_PTR_W-1:0];
        end
    end

    // Entry storage, no reset needed
    always_ff @(posedge CLK_SYS) begin
        if (do_push && !at_max) begin
            mem_q[ptr_q + `HRS_PTR_ONE] <= CORE_IN.pc;
        end else if (wr && !at_zero && !do_pop) begin
            if (hit(WB_REQ.adr, `HRS_ADR_TOPL)) begin
                mem_q[ptr_q][7:0] <= WB_REQ.dat[7:0];
            end else if (hit(WB_REQ.adr, `HRS_ADR_TOPH)) begin
                mem_q[ptr_q][15:8] <= WB_REQ.dat[7:0];
            end else if (hit(WB_REQ.adr, `HRS_ADR_TOPU)) begin
                mem_q[ptr_q][20:16] <=
                    WB_REQ.dat[`HRS_UPPER_W-1:0];
            end
        end
    end

    // Sticky flags: set wins over software clear
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            full_q <= 1'b0;
            unf_q <= 1'b0;
        end else begin
            if (ev_full) begin
                full_q <= 1'b1;
            end else if (wr && hit(WB_REQ.adr, `HRS_ADR_PTR) &&
                    !WB_REQ.dat[`HRS_BIT_FULL]) begin
                full_q <= 1'b0;
            end
            if (ev_unf) begin
                unf_q <= 1'b1;
            end else if (wr && hit(WB_REQ.adr, `HRS_ADR_PTR) &&
                    !WB_REQ.dat[`HRS_BIT_UNF]) begin
                unf_q <= 1'b0;
            end
        end
    end

    // Reset request pulses for one cycle, in the same cycle the flag sets
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            rst_req_q <= 1'b0;
        end else begin
            rst_req_q <= STACK_ERROR_RESET_ENABLE &&
                (ev_full || ev_unf);
        end
    end

    // Interrupt status, write one to clear
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ist_q <= 2'h0;
            imask_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if ((i == 0) ? ev_full : ev_unf) begin
                    ist_q[i] <= 1'b1;
                end else if (wr && hit(WB_REQ.adr, `HRS_ADR_ISTAT) &&
                        WB_REQ.dat[i]) begin
                    ist_q[i] <= 1'b0;
                end
            end
            if (wr && hit(WB_REQ.adr, `HRS_ADR_IMASK)) begin
                imask_q <= WB_REQ.dat[1:0];
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            irq_q <= 1'b0;
            top_q <= '0;
        end else begin
            irq_q <= |(ist_q & imask_q);
            top_q <= top_rd;
        end
    end

    // Bus answer, one cycle after the request
    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q <= acc;
            rdat_q <= 32'h0000_0000;
            if (acc && !WB_REQ.we) begin
                case (WB_REQ.adr)
                    `HRS_ADR_PTR: begin
                        // Bit 5 stays zero
                        rdat_q[7:0] <= {full_q, unf_q, 1'b0,
                            ptr_q};
                    end
                    `HRS_ADR_TOPL: begin
                        rdat_q[7:0] <= top_rd[7:0];
                    end
                    `HRS_ADR_TOPH: begin
                        rdat_q[7:0] <= top_rd[15:8];
                    end
                    `HRS_ADR_TOPU: begin
                        rdat_q[4:0] <= top_rd[20:16];
                    end
                    `HRS_ADR_ISTAT: begin
                        rdat_q[1:0] <= ist_q;
                    end
                    `HRS_ADR_IMASK: begin
                        rdat_q[1:0] <= imask_q;
                    end
                    `HRS_ADR_CFG: begin
                        rdat_q[`HRS_BIT_ENA] <= STACK_ERROR_RESET_ENABLE;
                    end
                    default: begin
                        rdat_q <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign WB_DAT_O = rdat_q;
    assign WB_ACK_O = ack_q;
    assign TOP_STACK_ENTRY = top_q;
    assign STACK_RESET_REQ = rst_req_q;
    assign IRQ = irq_q;
endmodule

// >>> src/hrs_params.svh
// Constants of the hardware return stack
// Function
// - Push: increment pointer, write current program counter into new top entry.
// - Pop: decrement pointer, previous entry becomes top.
// - Software reads and writes top entry via upper, high, low byte registers.
// - Full flag in bit 7 set when stack becomes full or overflows.
// - Underflow flag in bit 6 set when a stack underflow occurs.
// - Bit 5 of the pointer register always reads zero.
// - Bits 4 to 0 hold the pointer; software reads and writes them.
// - Flags stay set until software clears them or power-on reset.
// - With error reset enabled, full or underflow sets flag and requests reset in the same cycle.
// - With error reset disabled, full or underflow sets flag only.
`ifndef HRS_PARAMS_SVH
`define HRS_PARAMS_SVH
`define HRS_PTR_W 5
`define HRS_PC_W 21
`define HRS_DEPTH 31
`define HRS_PTR_MAX 5'h1f
`define HRS_PTR_ZERO 5'h00
`define HRS_PTR_ONE 5'h01
`define HRS_ADR_PTR 4'h0
`define HRS_ADR_TOPL 4'h1
`define HRS_ADR_TOPH 4'h2
`define HRS_ADR_TOPU 4'h3
`define HRS_ADR_ISTAT 4'h4
`define HRS_ADR_IMASK 4'h5
`define HRS_ADR_CFG 4'h6
`define HRS_BIT_FULL 7
`define HRS_BIT_UNF 6
`define HRS_BIT_PUSH 0
`define HRS_BIT_POP 1
`define HRS_BIT_ENA 0
`define HRS_UPPER_W 5
`endif

// >>> src/hrs_pkg.sv
// Types of the hardware return stack
package hrs_pkg;
    typedef struct packed {
        logic push;
        logic pop;
        logic [20:0] pc;
    } hrs_core_s;
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [3:0] sel;
        logic [5:2] adr;
        logic [31:0] dat;
    } hrs_wb_req_s;
endpackage

// >>> verif/hrs_props.sv
// Port assertions of the return stack
`timescale 1ns/100ps
module hrs_props (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire hrs_pkg::hrs_core_s CORE_IN,
    input wire logic STACK_ERROR_RESET_ENABLE,
    input wire hrs_pkg::hrs_wb_req_s WB_REQ,
    input wire logic WB_ACK_O,
    input wire logic [20:0] TOP_STACK_ENTRY,
    input wire logic STACK_RESET_REQ,
    input wire logic IRQ
);
    import hrs_pkg::*;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (RESET);
    wire take = WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O;
    wire op = CORE_IN.push || CORE_IN.pop;
    chk_ack_next: assert property (take |=> WB_ACK_O)
        else $error("no ack");
    chk_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("long ack");
    chk_ack_cause: assert property (WB_ACK_O |-> $past(take))
        else $error("stray ack");
    chk_push_top: assert property (CORE_IN.push |->
        ##2 TOP_STACK_ENTRY == $past(CORE_IN.pc, 2)) else $error("top");
    chk_reset_pulse: assert property (STACK_RESET_REQ |=>
        !STACK_RESET_REQ) else $error("long reset request");
    chk_reset_cause: assert property (STACK_RESET_REQ |->
        $past(op) && $past(STACK_ERROR_RESET_ENABLE)) else $error("stray");
    chk_reset_off: assert property (!$past(STACK_ERROR_RESET_ENABLE)
        |-> !STACK_RESET_REQ) else $error("reset while off");
    chk_irq_cause: assert property ($rose(IRQ) |->
        $past(op, 2) || $past(take && WB_REQ.we, 2)) else $error("irq");
endmodule
bind hrs_return_stack hrs_props u_hrs_props (.CLK_SYS, .RESET, .CORE_IN,
    .STACK_ERROR_RESET_ENABLE, .WB_REQ, .WB_ACK_O, .TOP_STACK_ENTRY,
    .STACK_RESET_REQ, .IRQ);

// >>> verif/hrs_core.sv
// Core sequencer model issuing push and pop
`timescale 1ns/100ps
module hrs_core (
    output hrs_pkg::hrs_core_s CORE_OUT,
    input wire logic CLK_SYS
);
    import hrs_pkg::*;
    initial CORE_OUT = '0;
    task automatic op(logic pu, logic po, logic [20:0] pc);
        @(posedge CLK_SYS) CORE_OUT <= {pu, po, pc};
        @(posedge CLK_SYS) CORE_OUT <= '0;
    endtask
endmodule

// >>> verif/tb_top.sv
// Self-checking bench of the return stack
`timescale 1ns/100ps
`include "hrs_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    mismatches++; $display("unexpected %0t %h", $time, a); end end
module tb_top;
    import hrs_pkg::*;
    logic clk = 0, rst = 1, ena = 0, ack, rrq, irq, seen = 0;
    hrs_wb_req_s req = '0;
    hrs_core_s core;
    logic [31:0] dat, r;
    logic [20:0] top;
    int mismatches = 0, num_checks = 0;
    always #2.5 clk = ~clk;
    always @(posedge clk) if (rrq === 1'b1) seen <= 1'b1;
    hrs_core u_hrs_core (.CLK_SYS(clk), .CORE_OUT(core));
    hrs_return_stack u_hrs_return_stack (.CLK_SYS(clk), .RESET(rst),
        .CORE_IN(core), .STACK_ERROR_RESET_ENABLE(ena), .WB_REQ(req),
        .WB_DAT_O(dat), .WB_ACK_O(ack), .TOP_STACK_ENTRY(top),
        .STACK_RESET_REQ(rrq), .IRQ(irq));
    task automatic wb(logic we, logic [3:0] a, logic [7:0] d);
        @(posedge clk) req <= {2'b11, we, 4'hf, a, 24'h0, d};
        do @(posedge clk); while (ack !== 1'b1);
        r = dat;
        req <= '0;
    endtask
    task automatic t_stack();
        wb(0, `HRS_ADR_PTR, 8'h00);
        `CHK(r[7:0], 8'h00)
        u_hrs_core.op(1, 0, 21'h1a_5c3e);
        u_hrs_core.op(1, 0, 21'h00_0abc);
        wb(0, `HRS_ADR_TOPL, 8'h00);
        `CHK(r[7:0], 8'hbc)
        u_hrs_core.op(0, 1, 21'h0);
        wb(0, `HRS_ADR_TOPU, 8'h00);
        `CHK(r[7:0], 8'h1a)
        wb(1, `HRS_ADR_TOPL, 8'h77);
        wb(0, `HRS_ADR_PTR, 8'h00);
        `CHK(r[7:0], 8'h01)
        `CHK(top, 21'h1a_5c77)
    endtask
    task automatic t_flags();
        wb(1, `HRS_ADR_PTR, 8'he5);
        wb(0, `HRS_ADR_PTR, 8'h00);
        `CHK(r[7:0], 8'h05)
        wb(0, 4'hf, 8'h00);
        `CHK(r, 32'h0000_0000)
        wb(1, `HRS_ADR_IMASK, 8'h03);
        wb(1, `HRS_ADR_PTR, 8'h00);
        u_hrs_core.op(0, 1, 21'h0);
        wb(0, `HRS_ADR_PTR, 8'h00);
        `CHK({r[7:0], irq, seen}, 10'h102)
        wb(1, `HRS_ADR_PTR, 8'hc0);
        wb(0, `HRS_ADR_PTR, 8'h00);
        `CHK(r[7:0], 8'h40)
        wb(1, `HRS_ADR_PTR, 8'h00);
        wb(1, `HRS_ADR_ISTAT, 8'h02);
        wb(0, `HRS_ADR_PTR, 8'h00);
        `CHK({r[7:0], irq}, 9'h000)
    endtask
    task automatic t_full();
        ena <= 1'b1;
        wb(1, `HRS_ADR_IMASK, 8'h00);
        wb(1, `HRS_ADR_PTR, 8'h1e);
        u_hrs_core.op(1, 0, 21'h00_0042);
        wb(0, `HRS_ADR_PTR, 8'h00);
        `CHK(r[7:0], 8'h9f)
        `CHK({irq, seen}, 2'b01)
        wb(0, `HRS_ADR_CFG, 8'h00);
        `CHK(r[7:0], 8'h01)
        ena <= 1'b0;
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_stack();
        t_flags();
        t_full();
        results();
    end
    initial begin
        #20000;
        mismatches++;
        results();
    end
endmodule
